// *** core/uebd_defs.svh ***
// Offsets, field positions, reset values and timing counts of the descriptor store
`ifndef UEBD_DEFS_SVH
`define UEBD_DEFS_SVH

`define UEBD_CFG_BASE       12'h000
`define UEBD_DESC_BASE      12'h080
`define UEBD_SECTRL_ADDR    12'h100
`define UEBD_SESTAT_ADDR    12'h104

`define UEBD_EP0_BUF_ADDR   16'h0100
`define UEBD_BUF_BYTES      16'h0040
`define UEBD_ISO_STEP_BASE  16'h0080

`define UEBD_CFG_EN         31
`define UEBD_CFG_DOUBLE     30
`define UEBD_CFG_IRQ_EACH   29
`define UEBD_CFG_IRQ_PAIR   28
`define UEBD_CFG_TYPE_HI    27
`define UEBD_CFG_TYPE_LO    26
`define UEBD_CFG_POLL_HI    25
`define UEBD_CFG_POLL_LO    18
`define UEBD_CFG_IRQ_STALL  17
`define UEBD_CFG_IRQ_NAK    16
`define UEBD_CFG_BASE_HI    15
`define UEBD_CFG_BASE_LO    6

`define UEBD_D1_FULL        31
`define UEBD_D1_LAST        30
`define UEBD_D1_PID         29
`define UEBD_D_ISO_HI       28
`define UEBD_D_ISO_LO       27
`define UEBD_D1_AVAIL       26
`define UEBD_D1_LEN_LO      16
`define UEBD_D0_FULL        15
`define UEBD_D0_LAST        14
`define UEBD_D0_PID         13
`define UEBD_D_RESET_SEL    12
`define UEBD_D_STALL        11
`define UEBD_D0_AVAIL       10

`define UEBD_SC_HOST        0
`define UEBD_SC_EP0_IRQ     1
`define UEBD_SC_EP0_STALL   2
`define UEBD_SC_EP0_NAK     3

`define UEBD_WORD_RESET     32'h0000_0000
`define UEBD_RESP_OKAY      2'h0
`define UEBD_RESP_SLVERR    2'h2

`define UEBD_CLK_PERIOD_PS  5000
`define UEBD_MS_PS          1000000000
`define UEBD_MS_CYCLES      (`UEBD_MS_PS / `UEBD_CLK_PERIOD_PS)

`endif

// *** core/uebd_pkg.sv ***
// Types shared by the descriptor store and its users
package uebd_pkg;
    typedef enum logic [1:0] {UEBD_CONTROL, UEBD_ISO, UEBD_BULK, UEBD_INTR} uebd_eptype_t;
    typedef enum logic [1:0] {UEBD_NONE, UEBD_CFG, UEBD_DESC, UEBD_CSR} uebd_kind_t;

    typedef struct packed {
        logic       hit;
        uebd_kind_t kind;
        logic [3:0] idx;
    } uebd_dec_t;

    // Buffer completion reported by the serial engine
    typedef struct packed {
        logic [3:0] ep;
        logic       out_dir;
        logic       failed;
        logic       periodic;
        logic [3:0] err_cause;
        logic [9:0] len;
        logic       pid;
        logic       last;
    } uebd_done_t;

    // Selected-buffer view handed to the serial engine
    typedef struct packed {
        logic         enabled;
        logic         double;
        uebd_eptype_t ep_type;
        logic         sel;
        logic         full;
        logic         avail;
        logic         last;
        logic         pid;
        logic         stall;
        logic [9:0]   len;
        logic [15:0]  buf_addr;
    } uebd_view_t;
endpackage

// *** core/uebd_top.sv ***
// Endpoint config and buffer descriptor store with AXI4-Lite access
// How it works
// - Endpoint zero: no config, buffers at 0x100
// - Endpoint zero irq enables from engine control
// - Bit 31 enables, bit 30 selects double
// - Bit 29 irq per buffer, 28 per pair
// - Bits 27:26 give endpoint type
// - Host polls interrupt endpoint every field+1 ms
// - Bits 15:6 give 64-byte aligned base
// - Single buffered uses only lower half
// - Selection starts at 0, alternates, resettable
// - Selection is internal, never software visible
// - Full set after OUT, cleared after IN
// - Bits 14 and 30 mark last buffer
// - Bits 13 and 29 carry data PID
// - Bits 28:27 set iso buffer spacing
// - Bit 12 resets selection in device mode only, cleared when the lower half is written back
// - Bit 11 commands stall, host reports received
// - Available cleared once buffer is used
// - Bits 9:0 and 25:16 hold lengths
// - Host periodic failure on endpoint zero still sets full, cause
// - Write-back touches only the used half
// - Write-back keeps length, PID, last; full per direction; zeroes rest
`timescale 1ns/100ps
`include "uebd_defs.svh"

module uebd_top
    import uebd_pkg::*;
#(
    parameter int NUM_EP    = 16,
    parameter int MS_CYCLES = `UEBD_MS_CYCLES
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [11:0]      awaddr,
    input  wire logic [2:0]       awprot,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [11:0]      araddr,
    input  wire logic [2:0]       arprot,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    input  wire logic [3:0]       look_ep,
    output uebd_view_t            view,
    input  wire logic             done_valid,
    input  wire uebd_done_t       done,
    input  wire logic             hs_valid,
    input  wire logic [3:0]       hs_ep,
    input  wire logic             hs_is_stall,
    output logic                  buf_irq,
    output logic [3:0]            buf_irq_ep,
    output logic                  hs_irq,
    output logic [NUM_EP-1:0]     poll_due
);
    if (NUM_EP < 2 || NUM_EP > 16) begin : g_check
        $error("NUM_EP must lie between 2 and 16");
    end
    if (MS_CYCLES < 1) begin : g_check_ms
        $error("MS_CYCLES must be at least 1");
    end

    function automatic uebd_dec_t decode(input logic [11:0] a);
        uebd_dec_t d;
        d = '0;
        if (a[1:0] == 2'h0) begin
            if (a >= `UEBD_CFG_BASE && a < `UEBD_CFG_BASE + 12'(NUM_EP * 4)) begin
                d = '{1'b1, UEBD_CFG, a[5:2]};
            end else if (a >= `UEBD_DESC_BASE && a < `UEBD_DESC_BASE + 12'(NUM_EP * 4)) begin
                d = '{1'b1, UEBD_DESC, a[5:2]};
            end else if (a == `UEBD_SECTRL_ADDR) begin
                d = '{1'b1, UEBD_CSR, 4'h0};
            end else if (a == `UEBD_SESTAT_ADDR) begin
                d = '{1'b1, UEBD_CSR, 4'h1};
            end
        end
        return d;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] cfg      [NUM_EP];
    logic [31:0] desc     [NUM_EP];
    logic [31:0] next_cfg [NUM_EP];
    logic [31:0] next_desc[NUM_EP];
    logic [NUM_EP-1:0] sel;
    logic [NUM_EP-1:0] next_sel;
    logic [NUM_EP-1:0] pair_odd;
    logic [31:0] se_ctrl;
    logic [3:0]  se_err;

    // Write channel: address and data taken together, one outstanding
    wire        wr_take = awvalid && wvalid && !bvalid;
    wire        rd_take = arvalid && !rvalid;
    uebd_dec_t  wdec;
    uebd_dec_t  rdec;
    assign wdec    = decode(awaddr);
    assign rdec    = decode(araddr);
    assign awready = wr_take;
    assign wready  = wr_take;
    assign arready = rd_take;

    wire host = se_ctrl[`UEBD_SC_HOST];

    // Completion context for the endpoint named by the engine
    wire [31:0] dcfg    = cfg[done.ep];
    wire [31:0] ddesc   = desc[done.ep];
    wire        ddouble = (done.ep != 4'h0) && dcfg[`UEBD_CFG_DOUBLE];
    wire        dsel    = ddouble && sel[done.ep];
    wire        dreset  = !host && ddesc[`UEBD_D_RESET_SEL];
    wire        dfull   = done.out_dir
                          || (host && done.failed && done.periodic && done.ep == 4'h0);
    wire [15:0] dhalf   = {dfull, done.last, done.pid, 3'h0, done.len};
    wire        d_each  = (done.ep == 4'h0) ? se_ctrl[`UEBD_SC_EP0_IRQ]
                                            : dcfg[`UEBD_CFG_IRQ_EACH];
    wire        d_pair  = ddouble && dcfg[`UEBD_CFG_IRQ_PAIR] && pair_odd[done.ep];
    wire        host_stall = hs_valid && hs_is_stall && host;
    logic [31:0] ms_div;
    logic        ms_tick_all;

    for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
        wire sw_cfg  = wr_take && wdec.hit && wdec.kind == UEBD_CFG && wdec.idx == 4'(i);
        wire sw_desc = wr_take && wdec.hit && wdec.kind == UEBD_DESC && wdec.idx == 4'(i);
        wire dn      = done_valid && done.ep == 4'(i);
        logic [31:0] d;
        always_comb begin
            d = sw_desc ? merge(desc[i], wdata, wstrb) : desc[i];
            // Engine half wins over a software write in the same cycle
            if (dn && !dsel) begin
                d[15:0] = dhalf;
            end
            if (dn && dsel) begin
                d[31:16] = dhalf;
            end
            if (host_stall && hs_ep == 4'(i)) begin
                d[`UEBD_D_STALL] = 1'b1;
            end
            next_desc[i] = d;
        end
        // Endpoint zero keeps no config word
        assign next_cfg[i] = (i == 0) ? `UEBD_WORD_RESET
                           : sw_cfg ? merge(cfg[i], wdata, wstrb) : cfg[i];
        assign next_sel[i] = !dn ? sel[i] : (!ddouble || dreset) ? 1'b0 : !sel[i];

        // Host poll interval counted in milliseconds
        logic [7:0] poll_cnt;
        logic       ms_tick;
        wire poll_on = host && (i != 0) && cfg[i][`UEBD_CFG_EN]
                       && cfg[i][`UEBD_CFG_TYPE_HI:`UEBD_CFG_TYPE_LO] == UEBD_INTR;
        always_ff @(posedge aclk) begin
            if (!aresetn || !poll_on) begin
                poll_cnt    <= 8'h00;
                poll_due[i] <= 1'b0;
            end else begin
                poll_due[i] <= ms_tick && poll_cnt == cfg[i][`UEBD_CFG_POLL_HI:`UEBD_CFG_POLL_LO];
                if (ms_tick) begin
                    poll_cnt <= (poll_cnt == cfg[i][`UEBD_CFG_POLL_HI:`UEBD_CFG_POLL_LO])
                                ? 8'h00 : poll_cnt + 8'h01;
                end
            end
        end
        assign ms_tick = ms_tick_all;
    end

    // Millisecond enable from a divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_div      <= 32'h0000_0000;
            ms_tick_all <= 1'b0;
        end else begin
            ms_tick_all <= ms_div == 32'(MS_CYCLES - 1);
            ms_div      <= (ms_div == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_div + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_EP; i++) begin
                cfg[i]  <= `UEBD_WORD_RESET;
                desc[i] <= `UEBD_WORD_RESET;
            end
            sel      <= '0;
            pair_odd <= '0;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                cfg[i]  <= next_cfg[i];
                desc[i] <= next_desc[i];
            end
            sel <= next_sel;
            if (done_valid) begin
                pair_odd[done.ep] <= ddouble && !pair_odd[done.ep];
            end
        end
    end

    // Engine control and sticky error cause; a new error beats the clear
    wire sw_ctrl = wr_take && wdec.hit && wdec.kind == UEBD_CSR && wdec.idx == 4'h0;
    wire sw_stat = wr_take && wdec.hit && wdec.kind == UEBD_CSR && wdec.idx == 4'h1;
    wire [3:0] err_set = (done_valid && done.failed && host) ? done.err_cause : 4'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            se_ctrl <= `UEBD_WORD_RESET;
            se_err  <= 4'h0;
        end else begin
            if (sw_ctrl) begin
                se_ctrl <= merge(se_ctrl, wdata, wstrb);
            end
            se_err <= (se_err & ~(sw_stat && wstrb[0] ? wdata[3:0] : 4'h0)) | err_set;
        end
    end

    // Interrupt requests toward the engine's interrupt logic
    wire [31:0] hcfg   = cfg[hs_ep];
    wire        hs_en  = (hs_ep == 4'h0)
                         ? se_ctrl[hs_is_stall ? `UEBD_SC_EP0_STALL : `UEBD_SC_EP0_NAK]
                         : hcfg[hs_is_stall ? `UEBD_CFG_IRQ_STALL : `UEBD_CFG_IRQ_NAK];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_irq    <= 1'b0;
            buf_irq_ep <= 4'h0;
            hs_irq     <= 1'b0;
        end else begin
            buf_irq    <= done_valid && (d_each || d_pair);
            buf_irq_ep <= done.ep;
            hs_irq     <= hs_valid && !host && hs_en;
        end
    end

    // Lookup view of the currently selected buffer
    wire [31:0] lcfg    = cfg[look_ep];
    wire [31:0] ldesc   = desc[look_ep];
    wire        lzero   = look_ep == 4'h0;
    wire        ldouble = !lzero && lcfg[`UEBD_CFG_DOUBLE];
    wire        lsel    = ldouble && sel[look_ep];
    wire        liso    = !lzero && lcfg[`UEBD_CFG_TYPE_HI:`UEBD_CFG_TYPE_LO] == UEBD_ISO;
    wire [15:0] lbase   = lzero ? `UEBD_EP0_BUF_ADDR
                        : {lcfg[`UEBD_CFG_BASE_HI:`UEBD_CFG_BASE_LO], 6'h00};
    wire [15:0] lstep   = liso ? (`UEBD_ISO_STEP_BASE << ldesc[`UEBD_D_ISO_HI:`UEBD_D_ISO_LO])
                        : `UEBD_BUF_BYTES;
    wire [15:0] lhalf   = lsel ? ldesc[31:16] : ldesc[15:0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            view <= '0;
        end else begin
            view.enabled  <= lzero || lcfg[`UEBD_CFG_EN];
            view.double   <= ldouble;
            view.ep_type  <= lzero ? UEBD_CONTROL
                           : uebd_eptype_t'(lcfg[`UEBD_CFG_TYPE_HI:`UEBD_CFG_TYPE_LO]);
            view.sel      <= lsel;
            view.full     <= lhalf[15];
            view.last     <= lhalf[14];
            view.pid      <= lhalf[13];
            view.avail    <= lsel ? ldesc[`UEBD_D1_AVAIL] : ldesc[`UEBD_D0_AVAIL];
            view.stall    <= ldesc[`UEBD_D_STALL];
            view.len      <= lhalf[9:0];
            view.buf_addr <= lsel ? lbase + lstep : lbase;
        end
    end

    // Bus responses; the selection bits are never mapped
    wire [31:0] rd_word = !rdec.hit ? 32'h0000_0000
                        : rdec.kind == UEBD_CFG  ? cfg[rdec.idx]
                        : rdec.kind == UEBD_DESC ? desc[rdec.idx]
                        : rdec.idx == 4'h0 ? se_ctrl : {28'h0, se_err};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `UEBD_RESP_OKAY;
            rvalid <= 1'b0;
            rresp  <= `UEBD_RESP_OKAY;
            rdata  <= 32'h0000_0000;
        end else begin
            if (wr_take) begin
                bvalid <= 1'b1;
                bresp  <= wdec.hit ? `UEBD_RESP_OKAY : `UEBD_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (rd_take) begin
                rvalid <= 1'b1;
                rresp  <= rdec.hit ? `UEBD_RESP_OKAY : `UEBD_RESP_SLVERR;
                rdata  <= rd_word;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Checks
    logic       done_q;
    uebd_done_t done_d;
    logic       dsel_q;
    logic       ddbl_q;
    logic       drst_q;
    logic       psel_q;
    always_ff @(posedge aclk) begin
        done_q <= done_valid;
        done_d <= done;
        dsel_q <= dsel;
        ddbl_q <= ddouble;
        drst_q <= dreset;
        psel_q <= sel[done.ep];
    end

    sequence s_ep0_cfg_read;
        rd_take && rdec.kind == UEBD_CFG && rdec.idx == 4'h0 && rdec.hit;
    endsequence
    property p_ep0_no_cfg;
        @(posedge aclk) disable iff (!aresetn)
        s_ep0_cfg_read |=> rvalid && rdata == 32'h0000_0000;
    endproperty
    a_ep0_no_cfg: assert property (p_ep0_no_cfg) else $error("ep0 config not zero");

    property p_ep0_base;
        @(posedge aclk) disable iff (!aresetn)
        look_ep == 4'h0 |=> view.buf_addr == 16'h0100 && !view.sel;
    endproperty
    a_ep0_base: assert property (p_ep0_base) else $error("ep0 buffer not at 0x100");

    property p_sel_flip;
        @(posedge aclk) disable iff (!aresetn)
        done_q && ddbl_q |-> sel[done_d.ep] == (drst_q ? 1'b0 : !psel_q);
    endproperty
    a_sel_flip: assert property (p_sel_flip) else $error("buffer select wrong");

    property p_single_sel;
        @(posedge aclk) disable iff (!aresetn)
        done_q && !ddbl_q |-> !sel[done_d.ep];
    endproperty
    a_single_sel: assert property (p_single_sel) else $error("single buffer selects 1");

    sequence s_done_low;
        done_q && !dsel_q;
    endsequence
    property p_writeback;
        @(posedge aclk) disable iff (!aresetn)
        s_done_low |-> desc[done_d.ep][9:0] == done_d.len && desc[done_d.ep][12:10] == 3'h0
                       && desc[done_d.ep][14] == done_d.last;
    endproperty
    a_writeback: assert property (p_writeback) else $error("write-back half wrong");

    property p_full_out;
        @(posedge aclk) disable iff (!aresetn)
        done_q && done_d.out_dir |-> desc[done_d.ep][dsel_q ? 31 : 15];
    endproperty
    a_full_out: assert property (p_full_out) else $error("full not set after OUT");

    property p_stall_irq;
        @(posedge aclk) disable iff (!aresetn)
        hs_valid && hs_is_stall && !host && hs_ep != 4'h0 && hcfg[17] |=> hs_irq;
    endproperty
    a_stall_irq: assert property (p_stall_irq) else $error("stall irq missing");

    property p_host_stall;
        @(posedge aclk) disable iff (!aresetn)
        host_stall |=> desc[$past(hs_ep)][11];
    endproperty
    a_host_stall: assert property (p_host_stall) else $error("stall not reported");

    property p_each_irq;
        @(posedge aclk) disable iff (!aresetn)
        done_valid && done.ep != 4'h0 && dcfg[29] |=> buf_irq ##1 (!buf_irq || $past(done_valid));
    endproperty
    a_each_irq: assert property (p_each_irq) else $error("buffer irq missing");
endmodule

// *** dv/uebd_engine_model.sv ***
// Serial engine stand-in that reports buffer completions and handshakes
`timescale 1ns/100ps

module uebd_engine_model
    import uebd_pkg::*;
(
    input  wire logic aclk,
    output logic       done_valid,
    output uebd_done_t done,
    output logic       hs_valid,
    output logic [3:0] hs_ep,
    output logic       hs_is_stall
);
    initial begin
        done_valid = 1'b0;
        done = '0;
        hs_valid = 1'b0;
        hs_ep = 4'h0;
        hs_is_stall = 1'b0;
    end

    // Released payload is inverted so a stale report never looks valid
    task automatic complete(input uebd_done_t d);
        done_valid <= 1'b1;
        done <= d;
        @(posedge aclk);
        done_valid <= 1'b0;
        done <= ~d;
        @(posedge aclk);
    endtask

    task automatic handshake(input logic [3:0] ep, input logic stall);
        hs_valid <= 1'b1;
        hs_ep <= ep;
        hs_is_stall <= stall;
        @(posedge aclk);
        hs_valid <= 1'b0;
        hs_ep <= ~ep;
        hs_is_stall <= ~stall;
        @(posedge aclk);
    endtask
endmodule

// *** dv/uebd_top_tb.sv ***
// Self-checking bench for the descriptor store
`timescale 1ns/100ps
`include "uebd_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end

module uebd_top_tb;
    import uebd_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, buf_irq, hs_irq;
    logic [1:0] bresp, rresp;
    logic [3:0] look_ep = 4'h0, wstrb = 4'hf, buf_irq_ep, hs_ep, birq_ep;
    logic done_valid, hs_valid, hs_is_stall;
    uebd_done_t done;
    uebd_view_t view;
    logic [15:0] poll_due;
    int n_fail = 0, checks = 0, cyc = 0, n_birq = 0, n_hirq = 0, p_last = 0, p_prev = 0;

    always #2.5 aclk = ~aclk;

    uebd_top #(.MS_CYCLES(10)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .look_ep(look_ep), .view(view),
        .done_valid(done_valid), .done(done), .hs_valid(hs_valid), .hs_ep(hs_ep),
        .hs_is_stall(hs_is_stall), .buf_irq(buf_irq), .buf_irq_ep(buf_irq_ep),
        .hs_irq(hs_irq), .poll_due(poll_due));

    uebd_engine_model eng (.aclk(aclk), .done_valid(done_valid), .done(done),
        .hs_valid(hs_valid), .hs_ep(hs_ep), .hs_is_stall(hs_is_stall));

    task automatic final_report;
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (buf_irq) begin
            n_birq <= n_birq + 1;
            birq_ep <= buf_irq_ep;
        end
        if (hs_irq) n_hirq <= n_hirq + 1;
        if (poll_due[3]) begin
            p_prev <= p_last;
            p_last <= cyc;
        end
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        `CHK(rdata, ed)
        `CHK(rresp, er)
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic viewchk(input logic [3:0] ep, input logic s, input logic [15:0] ad);
        look_ep <= ep;
        repeat (2) @(posedge aclk);
        `CHK(view.sel, s)
        `CHK(view.buf_addr, ad)
    endtask

    task automatic fin(input logic [3:0] ep, input logic o, f, p, input logic [3:0] c,
                       input logic [9:0] l, input logic pid, lst);
        eng.complete('{ep, o, f, p, c, l, pid, lst});
    endtask

    task automatic t_map;
        rdchk(12'h004, 32'h0, `UEBD_RESP_OKAY);
        wr(12'h000, 32'hffff_ffff, `UEBD_RESP_OKAY);
        rdchk(12'h000, 32'h0, `UEBD_RESP_OKAY);
        rdchk(12'h200, 32'h0, `UEBD_RESP_SLVERR);
        wr(12'h200, 32'h1, `UEBD_RESP_SLVERR);
        wr(12'h006, 32'h1, `UEBD_RESP_SLVERR);
        viewchk(4'h0, 1'b0, `UEBD_EP0_BUF_ADDR);
    endtask

    task automatic t_double;
        wr(12'h004, 32'he800_01bf, `UEBD_RESP_OKAY);
        // Fields first, availability in a later write
        wr(12'h084, 32'h0040_0040, `UEBD_RESP_OKAY);
        wr(12'h084, 32'h0440_0440, `UEBD_RESP_OKAY);
        viewchk(4'h1, 1'b0, 16'h0180);
        `CHK(view.ep_type, UEBD_BULK)
        `CHK({view.enabled, view.double, view.avail}, 3'h7)
        fin(4'h1, 1'b1, 1'b0, 1'b0, 4'h0, 10'h020, 1'b1, 1'b1);
        rdchk(12'h084, 32'h0440_e020, `UEBD_RESP_OKAY);
        viewchk(4'h1, 1'b1, 16'h01c0);
        fin(4'h1, 1'b0, 1'b0, 1'b0, 4'h0, 10'h011, 1'b0, 1'b0);
        rdchk(12'h084, 32'h0011_e020, `UEBD_RESP_OKAY);
        viewchk(4'h1, 1'b0, 16'h0180);
        `CHK(n_birq, 2)
        `CHK(birq_ep, 4'h1)
    endtask

    task automatic t_resel;
        wr(12'h084, 32'h0000_1400, `UEBD_RESP_OKAY);
        fin(4'h1, 1'b1, 1'b0, 1'b0, 4'h0, 10'h005, 1'b0, 1'b0);
        rdchk(12'h084, 32'h0000_8005, `UEBD_RESP_OKAY);
        viewchk(4'h1, 1'b0, 16'h0180);
    endtask

    task automatic t_single;
        wr(12'h008, 32'h8c02_0200, `UEBD_RESP_OKAY);
        wr(12'h088, 32'h1234_0000, `UEBD_RESP_OKAY);
        // Low lanes only, so the upper half keeps its value
        wstrb <= 4'h3;
        wr(12'h088, 32'hffff_0400, `UEBD_RESP_OKAY);
        wstrb <= 4'hf;
        fin(4'h2, 1'b0, 1'b0, 1'b0, 4'h0, 10'h007, 1'b0, 1'b0);
        rdchk(12'h088, 32'h1234_0007, `UEBD_RESP_OKAY);
        viewchk(4'h2, 1'b0, 16'h0200);
        wr(12'h010, 32'hd400_0400, `UEBD_RESP_OKAY);
        wr(12'h090, 32'h1000_0000, `UEBD_RESP_OKAY);
        fin(4'h4, 1'b1, 1'b0, 1'b0, 4'h0, 10'h008, 1'b0, 1'b0);
        rdchk(12'h090, 32'h1000_8008, `UEBD_RESP_OKAY);
        viewchk(4'h4, 1'b1, 16'h0600);
        `CHK(view.ep_type, UEBD_ISO)
        fin(4'h4, 1'b0, 1'b0, 1'b0, 4'h0, 10'h009, 1'b1, 1'b0);
        viewchk(4'h4, 1'b0, 16'h0400);
        `CHK(n_birq, 4)
        `CHK(birq_ep, 4'h4)
    endtask

    task automatic t_irq;
        eng.handshake(4'h2, 1'b1);
        eng.handshake(4'h1, 1'b0);
        repeat (2) @(posedge aclk);
        `CHK(n_hirq, 1)
        wr(`UEBD_SECTRL_ADDR, 32'h0000_0002, `UEBD_RESP_OKAY);
        fin(4'h0, 1'b1, 1'b0, 1'b0, 4'h0, 10'h001, 1'b0, 1'b0);
        repeat (2) @(posedge aclk);
        `CHK(n_birq, 5)
        `CHK(birq_ep, 4'h0)
    endtask

    task automatic t_host;
        wr(`UEBD_SECTRL_ADDR, 32'h0000_0001, `UEBD_RESP_OKAY);
        eng.handshake(4'h1, 1'b1);
        rdchk(12'h084, 32'h0000_8805, `UEBD_RESP_OKAY);
        `CHK(n_hirq, 1)
        fin(4'h0, 1'b0, 1'b1, 1'b1, 4'h5, 10'h003, 1'b0, 1'b0);
        rdchk(12'h080, 32'h0000_8003, `UEBD_RESP_OKAY);
        rdchk(`UEBD_SESTAT_ADDR, 32'h0000_0005, `UEBD_RESP_OKAY);
        wr(`UEBD_SESTAT_ADDR, 32'h0000_000f, `UEBD_RESP_OKAY);
        rdchk(`UEBD_SESTAT_ADDR, 32'h0, `UEBD_RESP_OKAY);
        // Poll field 1 means one poll every two milliseconds
        wr(12'h00c, 32'h8c04_0000, `UEBD_RESP_OKAY);
        repeat (60) @(posedge aclk);
        `CHK(p_last - p_prev, 20)
        wr(`UEBD_SECTRL_ADDR, 32'h0, `UEBD_RESP_OKAY);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_map();
        t_double();
        t_resel();
        t_single();
        t_irq();
        t_host();
        final_report();
    end
endmodule
